// ==== rtl/tcc_conv_ctrl.v ====
// conversion sequencer, offset correction and register file
// Function
// - remote fraction bits 4 and 3 zero unless filter on
// - reserved bits read zero, writes ignored
// - offsets are 8-bit two's complement, 0.5 lsb
// - offset range minus 64 to plus 63.5
// - offset added to raw, sum reported
// - standby bit stops periodic conversions
// - one-shot write in standby converts once
// - interval code selects conversion period
// - continuous mode restarts sequence immediately
// - enabled channels in turn, then rest, or standby after a one-shot or with the standby bit set
// - disabled channel skipped, reading kept
// - fixed periods hold length despite skips
// - enable bits: remote two, one, local
// - one-shot write-only, data not stored
// - filter codes 01 and 11 mean on
`timescale 1ns/100ps
`default_nettype none
`include "tcc_regs.vh"

module tcc_conv_ctrl #(
   parameter [31:0] PERIOD_364_CYC = `TCC_PERIOD_364_US * `TCC_CLK_MHZ,
   parameter [31:0] PERIOD_1S_CYC  = `TCC_PERIOD_1S_US * `TCC_CLK_MHZ,
   parameter [31:0] PERIOD_2S5_CYC = `TCC_PERIOD_2S5_US * `TCC_CLK_MHZ
) (
   // clock and reset
   input  wire        sys_clk_in,
   input  wire        rst_in,
   // register port, command byte addressed
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   input  wire [7:0]  reg_cmd_in,
   input  wire [7:0]  reg_wdata_in,
   output reg  [7:0]  reg_rdata_out,
   output reg         reg_rvalid_out,
   // converter front end
   output reg         conv_start_out,
   output reg  [1:0]  conv_chan_out,
   input  wire        conv_done_in,
   input  wire [15:0] conv_raw_in,
   // status
   output wire        busy_out
);

   // ========================================================
   // states
   localparam [1:0] ST_HOLD = 2'h0;
   localparam [1:0] ST_PICK = 2'h1;
   localparam [1:0] ST_CONV = 2'h2;
   localparam [1:0] ST_REST = 2'h3;

   // ========================================================
   // reset images, sliced to register width below
   localparam [7:0] CONFIG_RST = `TCC_CONFIG_RST;
   localparam [7:0] RATE_RST   = `TCC_RATE_RST;
   localparam [7:0] CHEN_RST   = `TCC_CHEN_RST;
   localparam [7:0] FILTER_RST = `TCC_FILTER_RST;

   // ========================================================
   // registers
   reg        low_power_hold_ff;
   reg [1:0]  sample_interval_sel_ff;
   reg [2:0]  chan_on_ff;
   reg [3:0]  smoothing_ff;
   reg [7:0]  remote_one_offset_ff;
   reg [7:0]  remote_two_offset_ff;
   reg [15:0] loc_read_ff;
   reg [15:0] rem_read_ff [0:1];
   reg [1:0]  state_ff;
   reg [1:0]  nxt_state;
   reg [1:0]  chan_ff;
   reg [1:0]  nxt_chan;
   reg        once_ff;
   reg        nxt_once;
   reg [31:0] per_cnt_ff;
   reg [31:0] nxt_per_cnt;
   reg        nxt_start;

   wire       remote_b_convert_on = chan_on_ff[2];
   wire       remote_a_convert_on = chan_on_ff[1];
   wire       onchip_convert_on   = chan_on_ff[0];
   wire [1:0] remote_a_smoothing  =
      smoothing_ff[`TCC_FILT_R1_LO +: 2];
   wire [1:0] remote_b_smoothing  =
      smoothing_ff[`TCC_FILT_R2_LO +: 2];
   wire [2:0] chan_mask =
      {remote_b_convert_on, remote_a_convert_on, onchip_convert_on};

   wire wr_hit_oneshot = reg_wr_in && (reg_cmd_in == `TCC_CMD_ONESHOT);
   wire [15:0] corr_sum [0:1];

   // ========================================================
   // functions
   function filt_on;
      input [1:0] code;
      begin
         filt_on = code[0];
      end
   endfunction

   function [7:0] frac_byte;
      input [7:0] lsb;
      input       on;
      begin
         frac_byte = `TCC_ZERO_BYTE;
         frac_byte[`TCC_FRAC_KEEP_MSB:`TCC_FRAC_KEEP_LSB] =
            lsb[`TCC_FRAC_KEEP_MSB:`TCC_FRAC_KEEP_LSB];
         frac_byte[`TCC_FRAC_F16_BIT] = on & lsb[`TCC_FRAC_F16_BIT];
         frac_byte[`TCC_FRAC_F32_BIT] = on & lsb[`TCC_FRAC_F32_BIT];
      end
   endfunction

   function [31:0] period_of;
      input [1:0] code;
      begin
         case (code)
            `TCC_RATE_364: period_of = PERIOD_364_CYC;
            `TCC_RATE_1S:  period_of = PERIOD_1S_CYC;
            `TCC_RATE_2S5: period_of = PERIOD_2S5_CYC;
            default:       period_of = 32'h0000_0000;
         endcase
      end
   endfunction

   // ========================================================
   // offset correction per remote channel
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_rem
         tcc_offset_add u_add (
            .raw_in    (conv_raw_in),
            .offset_in (gi == 0 ? remote_one_offset_ff
                                : remote_two_offset_ff),
            .sum_out   (corr_sum[gi])
         );
      end
   endgenerate

   // ========================================================
   // register writes
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         low_power_hold_ff     <= CONFIG_RST[`TCC_HOLD_BIT];
         sample_interval_sel_ff <= RATE_RST[`TCC_RATE_MSB:0];
         chan_on_ff            <= CHEN_RST[`TCC_CHEN_MSB:0];
         smoothing_ff          <= FILTER_RST[`TCC_FILT_MSB:0];
         remote_one_offset_ff  <= `TCC_OFFSET_RST;
         remote_two_offset_ff  <= `TCC_OFFSET_RST;
      end else if (reg_wr_in) begin
         case (reg_cmd_in)
            `TCC_CMD_CONFIG:
               low_power_hold_ff <= reg_wdata_in[`TCC_HOLD_BIT];
            `TCC_CMD_RATE:
               sample_interval_sel_ff <= reg_wdata_in[`TCC_RATE_MSB:0];
            `TCC_CMD_CHEN:
               chan_on_ff <= reg_wdata_in[`TCC_CHEN_MSB:0];
            `TCC_CMD_FILTER:
               smoothing_ff <= reg_wdata_in[`TCC_FILT_MSB:0];
            `TCC_CMD_R1_OFFSET:
               remote_one_offset_ff <= reg_wdata_in;
            `TCC_CMD_R2_OFFSET:
               remote_two_offset_ff <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // ========================================================
   // register reads, one cycle latency
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         reg_rdata_out  <= `TCC_ZERO_BYTE;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= `TCC_ZERO_BYTE;
            case (reg_cmd_in)
               `TCC_CMD_CONFIG:
                  reg_rdata_out[`TCC_HOLD_BIT] <= low_power_hold_ff;
               `TCC_CMD_RATE:
                  reg_rdata_out[`TCC_RATE_MSB:0] <= sample_interval_sel_ff;
               `TCC_CMD_CHEN:
                  reg_rdata_out[`TCC_CHEN_MSB:0] <= chan_on_ff;
               `TCC_CMD_FILTER:
                  reg_rdata_out[`TCC_FILT_MSB:0] <= smoothing_ff;
               `TCC_CMD_R1_OFFSET:
                  reg_rdata_out <= remote_one_offset_ff;
               `TCC_CMD_R2_OFFSET:
                  reg_rdata_out <= remote_two_offset_ff;
               `TCC_CMD_LOC_MSB:
                  reg_rdata_out <= loc_read_ff[15:8];
               `TCC_CMD_LOC_LSB:
                  reg_rdata_out <= frac_byte(loc_read_ff[7:0], 1'b0);
               `TCC_CMD_R1_MSB:
                  reg_rdata_out <= rem_read_ff[0][15:8];
               `TCC_CMD_R2_MSB:
                  reg_rdata_out <= rem_read_ff[1][15:8];
               `TCC_CMD_R1_LSB:
                  reg_rdata_out <= frac_byte(rem_read_ff[0][7:0],
                                             filt_on(remote_a_smoothing));
               `TCC_CMD_R2_LSB:
                  reg_rdata_out <= frac_byte(rem_read_ff[1][7:0],
                                             filt_on(remote_b_smoothing));
               default: ;
            endcase
         end
      end
   end

   // ========================================================
   // sequencer next state
   always @* begin
      nxt_state   = state_ff;
      nxt_chan    = chan_ff;
      nxt_once    = once_ff;
      nxt_start   = 1'b0;
      nxt_per_cnt = (state_ff == ST_HOLD) ? 32'h0000_0000
                                          : per_cnt_ff + 32'h0000_0001;
      case (state_ff)
         ST_HOLD: begin
            nxt_chan = `TCC_CH_LOCAL;
            if (!low_power_hold_ff) begin
               nxt_state = ST_PICK;
               nxt_once  = 1'b0;
            end else if (wr_hit_oneshot) begin
               nxt_state = ST_PICK;
               nxt_once  = 1'b1;
            end
         end
         ST_PICK: begin
            if (chan_ff == `TCC_CH_END) begin
               if (once_ff || low_power_hold_ff) begin
                  nxt_state = ST_HOLD;
               end else if (sample_interval_sel_ff == `TCC_RATE_CONT) begin
                  nxt_chan    = `TCC_CH_LOCAL;
                  nxt_per_cnt = 32'h0000_0000;
               end else begin
                  nxt_state = ST_REST;
               end
            end else if (chan_mask[chan_ff]) begin
               nxt_start = 1'b1;
               nxt_state = ST_CONV;
            end else begin
               nxt_chan = chan_ff + 2'h1;
            end
         end
         ST_CONV: begin
            if (conv_done_in) begin
               nxt_chan  = chan_ff + 2'h1;
               nxt_state = ST_PICK;
            end
         end
         ST_REST: begin
            if (low_power_hold_ff && wr_hit_oneshot) begin
               nxt_state   = ST_PICK;
               nxt_chan    = `TCC_CH_LOCAL;
               nxt_once    = 1'b1;
               nxt_per_cnt = 32'h0000_0000;
            end else if (low_power_hold_ff) begin
               nxt_state = ST_HOLD;
            end else if (sample_interval_sel_ff == `TCC_RATE_CONT ||
                         per_cnt_ff + 32'h0000_0001 >=
                         period_of(sample_interval_sel_ff)) begin
               nxt_state   = ST_PICK;
               nxt_chan    = `TCC_CH_LOCAL;
               nxt_per_cnt = 32'h0000_0000;
            end
         end
         default: nxt_state = ST_HOLD;
      endcase
   end

   // ========================================================
   // sequencer registers and result capture
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_ff       <= ST_HOLD;
         chan_ff        <= `TCC_CH_LOCAL;
         once_ff        <= 1'b0;
         per_cnt_ff     <= 32'h0000_0000;
         conv_start_out <= 1'b0;
         conv_chan_out  <= `TCC_CH_LOCAL;
         loc_read_ff    <= 16'h0000;
         rem_read_ff[0] <= 16'h0000;
         rem_read_ff[1] <= 16'h0000;
      end else begin
         state_ff       <= nxt_state;
         chan_ff        <= nxt_chan;
         once_ff        <= nxt_once;
         per_cnt_ff     <= nxt_per_cnt;
         conv_start_out <= nxt_start;
         if (nxt_start) begin
            conv_chan_out <= chan_ff;
         end
         if (state_ff == ST_CONV && conv_done_in) begin
            case (chan_ff)
               `TCC_CH_LOCAL: loc_read_ff    <= conv_raw_in;
               `TCC_CH_REM_A: rem_read_ff[0] <= corr_sum[0];
               `TCC_CH_REM_B: rem_read_ff[1] <= corr_sum[1];
               default: ;
            endcase
         end
      end
   end

   assign busy_out = (state_ff == ST_PICK) || (state_ff == ST_CONV);

endmodule // tcc_conv_ctrl

`default_nettype wire

// ==== include/tcc_regs.vh ====
// register map, field positions, reset values and timing for tcc block
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// ===========================================================
// command bytes
`define TCC_CMD_CONFIG      8'h03
`define TCC_CMD_RATE        8'h04
`define TCC_CMD_CHEN        8'h05
`define TCC_CMD_FILTER      8'h06
`define TCC_CMD_ONESHOT     8'h0F
`define TCC_CMD_LOC_MSB     8'h10
`define TCC_CMD_R1_MSB      8'h11
`define TCC_CMD_R2_MSB      8'h12
`define TCC_CMD_LOC_LSB     8'h20
`define TCC_CMD_R1_LSB      8'h21
`define TCC_CMD_R2_LSB      8'h22
`define TCC_CMD_R1_OFFSET   8'h31
`define TCC_CMD_R2_OFFSET   8'h32

// ===========================================================
// reset values
`define TCC_CONFIG_RST      8'h00
`define TCC_RATE_RST        8'h02
`define TCC_CHEN_RST        8'h1F
`define TCC_FILTER_RST      8'h0F
`define TCC_OFFSET_RST      8'h00
`define TCC_ZERO_BYTE       8'h00

// ===========================================================
// field positions
`define TCC_HOLD_BIT        6
`define TCC_RATE_MSB        1
`define TCC_CHEN_MSB        2
`define TCC_FILT_MSB        3
`define TCC_FILT_R1_LO      0
`define TCC_FILT_R2_LO      2
`define TCC_FRAC_KEEP_MSB   7
`define TCC_FRAC_KEEP_LSB   5
`define TCC_FRAC_F16_BIT    4
`define TCC_FRAC_F32_BIT    3

// ===========================================================
// interval codes and periods
`define TCC_RATE_CONT       2'h0
`define TCC_RATE_364        2'h1
`define TCC_RATE_1S         2'h2
`define TCC_RATE_2S5        2'h3
`define TCC_PERIOD_364_US   364000
`define TCC_PERIOD_1S_US    1000000
`define TCC_PERIOD_2S5_US   2500000
`define TCC_CLK_MHZ         200

// ===========================================================
// channel indices
`define TCC_CH_LOCAL        2'h0
`define TCC_CH_REM_A        2'h1
`define TCC_CH_REM_B        2'h2
`define TCC_CH_END          2'h3

`endif

// ==== rtl/tcc_offset_add.v ====
// signed offset correction for one remote channel
`timescale 1ns/100ps
`default_nettype none

module tcc_offset_add (
   // raw reading, 1/256 degree units
   input  wire [15:0] raw_in,
   // offset, 1/2 degree units
   input  wire [7:0]  offset_in,
   // corrected reading
   output reg  [15:0] sum_out
);

   // ========================================================
   // add and saturate
   reg [16:0] ext_raw;
   reg [16:0] ext_off;
   reg [16:0] wide_sum;

   always @* begin
      ext_raw  = {raw_in[15], raw_in};
      // sign extend, shift to 1/256 units
      ext_off  = {{2{offset_in[7]}}, offset_in, 7'h00};
      wide_sum = ext_raw + ext_off;
      if (wide_sum[16] != wide_sum[15]) begin
         sum_out = wide_sum[16] ? 16'h8000 : 16'h7FFF;
      end else begin
         sum_out = wide_sum[15:0];
      end
   end

endmodule // tcc_offset_add

`default_nettype wire

// ==== testbench/tcc_conv_ctrl_properties.sv ====
// port checker for the conversion controller
`timescale 1ns/100ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_conv_ctrl_properties (
   // clock, reset, register port
   input wire logic       sys_clk_in,
   input wire logic       rst_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_cmd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       reg_rvalid_out,
   // sequencer
   input wire logic       conv_start_out,
   input wire logic [1:0] conv_chan_out,
   input wire logic       busy_out
);
   // ======================================
   // register mirrors
   logic       hold_ff;
   logic [1:0] rate_ff;
   logic [2:0] chen_ff;
   logic [2:0] chen_d_ff;
   logic       os_run_ff;
   wire        os_wr = reg_wr_in && reg_cmd_in == `TCC_CMD_ONESHOT;
   wire        rd_ok = reg_rd_in;
   // enable value used one cycle ago, one-shot sequence in flight
   always_ff @(posedge sys_clk_in) begin
      chen_d_ff <= rst_in ? 3'h7 : chen_ff;
      if (rst_in)
         os_run_ff <= 1'b0;
      else if (os_wr && hold_ff && !busy_out)
         os_run_ff <= 1'b1;
      else if (!busy_out)
         os_run_ff <= 1'b0;
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         hold_ff <= 1'b0;
         rate_ff <= 2'h2;
         chen_ff <= 3'h7;
      end else if (reg_wr_in) begin
         if (reg_cmd_in == `TCC_CMD_CONFIG)
            hold_ff <= reg_wdata_in[6];
         if (reg_cmd_in == `TCC_CMD_RATE)
            rate_ff <= reg_wdata_in[1:0];
         if (reg_cmd_in == `TCC_CMD_CHEN)
            chen_ff <= reg_wdata_in[2:0];
      end
   end
   // ======================================
   // properties
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   AST_START_BUSY: assert property (
      conv_start_out |-> busy_out)
      else $error("start outside sequence");
   AST_START_EN: assert property (
      conv_start_out |-> chen_d_ff[conv_chan_out])
      else $error("disabled channel started");
   AST_CONT: assert property (
      !os_run_ff && !hold_ff && rate_ff == `TCC_RATE_CONT &&
      $past(!hold_ff && rate_ff == `TCC_RATE_CONT) |-> !$fell(busy_out))
      else $error("rest in continuous mode");
   AST_ONESHOT: assert property (
      hold_ff && !busy_out && os_wr |-> ##[1:3] busy_out)
      else $error("one-shot did not start");
   AST_ONESHOT_END: assert property (
      (hold_ff && $fell(busy_out) && !os_wr) ##1 (hold_ff && !os_wr)
      |-> !busy_out [*2])
      else $error("restart after one-shot");
   AST_HOLD_IDLE: assert property (
      hold_ff && !busy_out && !reg_wr_in |=> !busy_out)
      else $error("conversion in standby");
   AST_CFG_RSVD: assert property (
      rd_ok && reg_cmd_in == `TCC_CMD_CONFIG |=>
      reg_rvalid_out && (reg_rdata_out & 8'hBF) == 8'h00)
      else $error("config reserved bits");
   AST_CHEN_RD: assert property (
      rd_ok && reg_cmd_in == `TCC_CMD_CHEN |=>
      reg_rdata_out == {5'h00, chen_d_ff})
      else $error("enable readback");
   AST_OS_RD: assert property (
      rd_ok && reg_cmd_in == `TCC_CMD_ONESHOT |=> reg_rdata_out == 8'h00)
      else $error("one-shot readback");
   cover property (conv_start_out && conv_chan_out == `TCC_CH_REM_B);
   cover property (hold_ff && $fell(busy_out));
   cover property (os_wr && hold_ff && !busy_out);
endmodule // tcc_conv_ctrl_properties
`default_nettype wire

// ==== testbench/tcc_conv_model.sv ====
// converter front end model, latency set by the bench
`timescale 1ns/100ps
`default_nettype none
module tcc_conv_model (
   // sequencer side
   input  wire logic        clk_in,
   input  wire logic        start_in,
   input  wire logic [1:0]  chan_in,
   // bench controls
   input  wire logic [7:0]  lat_in,
   input  wire logic [15:0] raw_in,
   // results
   output logic             done_out,
   output logic [15:0]      raw_out
);
   // ======================================
   // conversion timer
   logic [7:0] cnt_ff;
   logic [1:0] chan_ff;
   initial {cnt_ff, done_out, raw_out} = 25'h0;
   always @(posedge clk_in) begin
      done_out <= 1'b0;
      raw_out <= ~raw_out;
      if (start_in) begin
         cnt_ff <= lat_in;
         chan_ff <= chan_in;
      end else if (cnt_ff == 8'h01) begin
         cnt_ff <= 8'h00;
         done_out <= 1'b1;
         raw_out <= raw_in + {6'h00, chan_ff, 8'h00};
      end else if (cnt_ff != 8'h00)
         cnt_ff <= cnt_ff - 8'h01;
   end
endmodule // tcc_conv_model
`default_nettype wire

// ==== testbench/tb_temp_conversion_control.sv ====
// self-checking bench for the conversion controller
`timescale 1ns/100ps
`default_nettype none
`include "tcc_regs.vh"
module tb_temp_conversion_control;
   localparam int P1 = 200, P2 = 400, P3 = 800;
   logic clk = 0, rst = 1, wr = 0, rd = 0, done, start, busy, rv;
   logic [7:0] cmd = 0, wd = 0, rdat, lat = 8'h04;
   logic [15:0] raw = 0, craw;
   logic [1:0] chan;
   int miscompares = 0, comparisons = 0, cyc = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc++;
   tcc_conv_ctrl #(.PERIOD_364_CYC(P1), .PERIOD_1S_CYC(P2),
      .PERIOD_2S5_CYC(P3)) i_dut (
      .sys_clk_in(clk), .rst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_cmd_in(cmd), .reg_wdata_in(wd), .reg_rdata_out(rdat),
      .reg_rvalid_out(rv), .conv_start_out(start), .conv_chan_out(chan),
      .conv_done_in(done), .conv_raw_in(craw), .busy_out(busy));
   tcc_conv_model i_conv (.clk_in(clk), .start_in(start),
      .chan_in(chan), .lat_in(lat), .raw_in(raw), .done_out(done),
      .raw_out(craw));
   // ======================================
   // tasks
   task automatic chk(input string n, input logic [31:0] e, s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %0h got %0h", n, e, s);
      end
   endtask
   task automatic wr_reg(input logic [7:0] c, d);
      @(posedge clk) #1;
      {wr, cmd, wd} = {1'b1, c, d};
      @(posedge clk) #1;
      wr = 0;
   endtask
   task automatic rdc(input logic [7:0] c, e);
      @(posedge clk) #1;
      {rd, cmd} = {1'b1, c};
      @(posedge clk) #1;
      rd = 0;
      chk($sformatf("cmd %h", c), {1'b1, e}, {rv, rdat});
   endtask
   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clk) #1;
         n++;
      end while (busy !== v && n < 3000);
      chk("busy", v, busy);
   endtask
   function automatic logic [15:0] corr(input logic [15:0] r,
      input logic [7:0] o);
      logic signed [17:0] s;
      s = $signed({{2{r[15]}}, r}) + $signed({{3{o[7]}}, o, 7'h00});
      if (s > 18'sh07FFF)
         return 16'h7FFF;
      if (s < -18'sh08000)
         return 16'h8000;
      return s[15:0];
   endfunction
   task final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ======================================
   // tests
   initial begin
      logic [7:0] oa, ob, ce, fl;
      logic [15:0] ex [3];
      logic f;
      int seed, t0, n;
      seed = $urandom(32'hD161);
      ex = '{16'h0000, 16'h0100, 16'h0200};
      repeat (10) @(posedge clk);
      #1 rst = 0;
      rdc(`TCC_CMD_CONFIG, 8'h00);
      rdc(`TCC_CMD_RATE, 8'h02);
      rdc(`TCC_CMD_CHEN, 8'h07);
      rdc(`TCC_CMD_FILTER, 8'h0F);
      rdc(`TCC_CMD_R1_OFFSET, 8'h00);
      rdc(`TCC_CMD_ONESHOT, 8'h00);
      rdc(8'h01, 8'h00);
      wr_reg(`TCC_CMD_CONFIG, 8'hFF);
      rdc(`TCC_CMD_CONFIG, 8'h40);
      wait_busy(0);
      for (int it = 0; it < 6; it++) begin
         oa = it ? 8'($urandom) : 8'h7F;
         ob = it ? 8'($urandom) : 8'h80;
         ce = 8'($urandom);
         ce[0] = ce[0] | (ce[2:1] == 2'h0);
         fl = 8'($urandom);
         raw = it ? 16'($urandom) : 16'h7F00;
         lat = 8'($urandom_range(20, 1));
         wr_reg(`TCC_CMD_R1_OFFSET, oa);
         wr_reg(`TCC_CMD_R2_OFFSET, ob);
         wr_reg(`TCC_CMD_CHEN, ce);
         wr_reg(`TCC_CMD_FILTER, fl);
         rdc(`TCC_CMD_R1_OFFSET, oa);
         rdc(`TCC_CMD_R2_OFFSET, ob);
         rdc(`TCC_CMD_FILTER, {4'h0, fl[3:0]});
         wr_reg(`TCC_CMD_ONESHOT, 8'($urandom));
         wait_busy(1);
         wr_reg(`TCC_CMD_ONESHOT, 8'h00);
         wait_busy(0);
         for (int c = 0; c < 3; c++) begin
            f = c == 1 ? fl[0] : c == 2 ? fl[2] : 1'b0;
            if (ce[c])
               ex[c] = c ? corr(raw + (16'(c) << 8), c == 1 ? oa : ob) : raw;
            rdc(`TCC_CMD_LOC_MSB + 8'(c), ex[c][15:8]);
            rdc(`TCC_CMD_LOC_LSB + 8'(c),
               {ex[c][7:5], ex[c][4:3] & {f, f}, 3'h0});
         end
      end
      wr_reg(`TCC_CMD_RATE, 8'hFD);
      rdc(`TCC_CMD_RATE, 8'h01);
      for (int r = 0; r < 8; r++) begin
         lat = 8'($urandom_range(20, 1));
         wr_reg(`TCC_CMD_CHEN, 8'($urandom_range(7, 1)));
         wr_reg(`TCC_CMD_RATE, 8'(r / 2));
         wr_reg(`TCC_CMD_CONFIG, 8'h00);
         wait_busy(1);
         t0 = cyc;
         if (r < 2) begin
            n = 0;
            repeat (300) begin
               @(posedge clk) #1;
               n += (busy !== 1'b1);
            end
            chk("rest cycles", 0, n);
         end else begin
            wait_busy(0);
            wait_busy(1);
            chk("period", r < 4 ? P1 : r < 6 ? P2 : P3, cyc - t0);
         end
         wr_reg(`TCC_CMD_CONFIG, 8'h40);
         wait_busy(0);
      end
      final_report;
   end
   initial begin
      #200000;
      miscompares++;
      final_report;
   end
endmodule // tb_temp_conversion_control
bind tcc_conv_ctrl tcc_conv_ctrl_properties i_chk (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_cmd_in(reg_cmd_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .reg_rvalid_out(reg_rvalid_out), .conv_start_out(conv_start_out),
   .conv_chan_out(conv_chan_out), .busy_out(busy_out));
`default_nettype wire
